// >>> pkg/wutc_pkg.sv
package wutc_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PRESCALE = 10'h316;
  localparam logic [9:0] IDX_SLEEP = 10'h317;
  localparam logic [9:0] IDX_RELOAD_HI = 10'h318;
  localparam logic [9:0] IDX_RELOAD_LO = 10'h319;
  localparam logic [9:0] IDX_CONTROL = 10'h31A;
  localparam logic [9:0] IDX_STATUS = 10'h31B;
  // Reset values
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  localparam logic [3:0] RST_SLEEP_MODE = 4'h0;
  localparam logic [7:0] RST_RELOAD_BYTE = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  // Field positions
  localparam int POS_WAKE_EN = 0;
  localparam int POS_MODE_LO = 3;
  localparam int POS_FLAG_CLR = 0;
  localparam int POS_CAL_EN = 1;
  localparam int POS_TIMEOUT = 1;
  localparam int POS_COLD = 2;
  localparam int POS_XTAL_OK = 4;
  localparam int POS_CAL_DONE = 5;
  // Sleep mode codes
  typedef enum logic [3:0] {
    WUTC_SLEEP_RAM_RETAINED = 4'h1,
    WUTC_SLEEP_CRYSTAL_ON = 4'h4,
    WUTC_SLEEP_RAM_AND_CRYSTAL = 4'h5,
    WUTC_SLEEP_RAM_AND_RC = 4'hB
  } wutc_sleep_t;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Calibration time
  localparam int CLK_MHZ = 125;
  localparam int CALIB_TIME_US = 1000;
  localparam int CALIB_CYCLES = CALIB_TIME_US * CLK_MHZ;
endpackage : wutc_pkg

// >>> pkg/wutc_timer_if.sv
`timescale 1ns/10ps
interface wutc_timer_if;
  logic load; // Apply reload value now
  logic [15:0] reload; // Applied reload value
  logic [2:0] div_code; // Applied prescaler code
  logic src_edge; // One pulse per slow source rising edge
  logic timeout; // One pulse per expiry
  modport ctrl (output load, reload, div_code, src_edge, input timeout);
  modport timer (input load, reload, div_code, src_edge, output timeout);
endinterface : wutc_timer_if

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import wutc_pkg::*;
  // Bench drive
  logic clk, rst_n, awv, wv, brdy, arv, rrdy, rc, settled, rc_run;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] rs;
  logic [2:0] cnt;
  // Design outputs
  logic awr, wr_o, bv, arr, rv, ram_o, xo_o, rco_o, wake, cal_o;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  int miscompares, checks, n;
  // Short calibration keeps the run brief
  wutc_top #(.CALIB_CYCLES_P(20)) wutc_top_inst (.CLK_I(clk),
    .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_o), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy),
    .SLOW_CRYSTAL_SOURCE_I(rc), .SLOW_RC_SOURCE_I(rc),
    .SLOW_CRYSTAL_SETTLED_I(settled), .SLEEP_RAM_RETAINED_O(ram_o),
    .SLEEP_CRYSTAL_ON_O(xo_o), .SLEEP_RC_ON_O(rco_o), .WAKE_REQ_O(wake),
    .SLOW_RC_CALIB_ENABLE_O(cal_o));
  // 125 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slow source, period of ten system clocks, held while stopped
  always @(posedge clk)
  begin
    if (rc_run)
    begin
      cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      if (cnt == 3'h4) rc <= ~rc;
    end
  end
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // A wait that ran out ends the run
  task automatic bail;
    miscompares++;
    report_and_stop();
  endtask : bail
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One write; channels released each at its own handshake
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_o) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    brdy <= 1'b0;
    rs = br;
    if (n == 50) bail();
  endtask : wr
  task automatic rdr(input logic [9:0] idx);
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rrdy <= 1'b0;
    rd = rdat;
    rs = rr;
    if (n == 50) bail();
  endtask : rdr
  task automatic next_pulse(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end while (wake !== 1'b1 && c < 30000);
    if (c == 30000) bail();
  endtask : next_pulse
  // Second interval is clean of any restart after a write
  task automatic period(input int exp);
    int c;
    next_pulse(c);
    next_pulse(c);
    chk("wake period", c, exp);
  endtask : period
  initial
  begin
    int k;
    logic [3:0] codes [6] = '{4'h1, 4'h4, 4'h5, 4'hB, 4'h0, 4'h6};
    logic [2:0] mexp [6] = '{3'h4, 3'h2, 3'h6, 3'h5, 3'h0, 3'h0};
    int divs [5] = '{1, 4, 8, 16, 128};
    {rst_n, awv, wv, brdy, arv, rrdy, rc, settled, rc_run} = 9'h000;
    {cnt, awa, ara, wd} = '0;
    miscompares = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      rdr(IDX_PRESCALE + 10'(i));
      chk("reset value", rd, (i == 5) ? 32'h04 : 32'h00);
      chk("reset resp", rs, RESP_OKAY);
    end
    wr(IDX_STATUS, 8'hFF);
    rdr(IDX_STATUS);
    chk("status write", rd, 32'h04);
    wr(IDX_CONTROL, 8'h01);
    rdr(IDX_STATUS);
    chk("flag reset", rd, 32'h00);
    rdr(10'h000);
    chk("unmapped read", rs, RESP_SLVERR);
    wr(10'h320, 8'h01);
    chk("unmapped write", rs, RESP_SLVERR);
    // The four defined sleep codes, plus reserved codes 0 and 6
    for (int i = 0; i < 6; i++)
    begin
      wr(IDX_SLEEP, {1'b0, codes[i], 3'h0});
      repeat (2) @(posedge clk);
      chk("sleep outputs", {ram_o, xo_o, rco_o}, mexp[i]);
      rdr(IDX_SLEEP);
      chk("sleep readback", rd, {codes[i], 3'h0});
    end
    settled <= 1'b1;
    wr(IDX_SLEEP, 8'h20);
    repeat (4) @(posedge clk);
    rdr(IDX_STATUS);
    chk("crystal settled", rd[4], 1'b1);
    settled <= 1'b0;
    wr(IDX_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    chk("calib enable", cal_o, 1'b1);
    rdr(IDX_STATUS);
    chk("calib running", rd[5], 1'b0);
    repeat (25) @(posedge clk);
    rdr(IDX_STATUS);
    chk("calib done", rd[5], 1'b1);
    wr(IDX_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    rdr(IDX_STATUS);
    chk("calib off", {cal_o, rd[5]}, 2'h0);
    // Reload zero, prescaler codes 0 to 4 each applied by a sleep write
    wr(IDX_RELOAD_HI, 8'h00);
    wr(IDX_RELOAD_LO, 8'h00);
    rc_run <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(IDX_PRESCALE, 8'(i));
      wr(IDX_SLEEP, 8'h09);
      period(divs[i] * 10);
    end
    rdr(IDX_STATUS);
    chk("timeout flag", rd[1], 1'b1);
    wr(IDX_PRESCALE, 8'h00);
    period(1280);
    wr(IDX_SLEEP, 8'h09);
    wr(IDX_RELOAD_HI, 8'h01);
    period(10);
    wr(IDX_RELOAD_LO, 8'h03);
    period(2600);
    rdr(IDX_RELOAD_LO);
    chk("reload low", rd, 32'h03);
    // Clear flags first, then wait past one whole 2600-cycle period
    wr(IDX_CONTROL, 8'h01);
    wr(IDX_SLEEP, 8'h08);
    k = 0;
    repeat (3000)
    begin
      @(posedge clk);
      if (wake === 1'b1) k++;
    end
    chk("wake disabled", k, 0);
    rdr(IDX_STATUS);
    chk("idle timeout", rd[1], 1'b1);
    rc_run <= 1'b0;
    repeat (50) @(posedge clk);
    wr(IDX_CONTROL, 8'h01);
    rdr(IDX_STATUS);
    chk("flags cleared", rd[2:1], 2'h0);
    report_and_stop();
  end
endmodule : tb_top

// >>> verif/wutc_top_chk.sv
`timescale 1ns/10ps
module wutc_top_chk
  import wutc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // Bus handshakes
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [wutc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [wutc_pkg::DATA_W-1:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Sleep and wake outputs
  input wire logic SLEEP_RAM_RETAINED_O,
  input wire logic SLEEP_CRYSTAL_ON_O,
  input wire logic SLEEP_RC_ON_O,
  input wire logic WAKE_REQ_O
);
  // Read index inside the six-register block
  wire logic ar_mapped;
  assign ar_mapped = (S_AXI_ARADDR_I[11:2] >= IDX_PRESCALE) &&
    (S_AXI_ARADDR_I[11:2] <= IDX_STATUS);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
    S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O)
    else $error("write response late");
  a_write_busy: assert property (S_AXI_BVALID_O |->
    !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("ready while busy");
  a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("bresp dropped");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
    S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read answer late");
  a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("rdata dropped");
  a_rdata_upper: assert property (S_AXI_RVALID_O |->
    S_AXI_RDATA_O[31:8] == 24'h000000) else $error("upper read bits set");
  a_unmapped_err: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
    !ar_mapped |=> S_AXI_RRESP_O == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_wake_pulse: assert property (WAKE_REQ_O |=> !WAKE_REQ_O)
    else $error("wake request too long");
  a_mode_exclusive: assert property (
    !(SLEEP_CRYSTAL_ON_O && SLEEP_RC_ON_O))
    else $error("crystal and rc both on");
  a_rc_with_ram: assert property (
    SLEEP_RC_ON_O |-> SLEEP_RAM_RETAINED_O)
    else $error("rc mode without ram");
endmodule : wutc_top_chk
bind wutc_top wutc_top_chk wutc_top_chk_inst (.CLK_I, .RESET_N_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
  .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
  .S_AXI_RVALID_O, .S_AXI_RREADY_I, .SLEEP_RAM_RETAINED_O,
  .SLEEP_CRYSTAL_ON_O, .SLEEP_RC_ON_O, .WAKE_REQ_O);

// >>> verilog/wutc_sync.sv
`timescale 1ns/10ps
module wutc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg; // First stage, read only by second
  logic [W-1:0] q_reg; // Second stage

  // Two-flop synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule : wutc_sync

// >>> verilog/wutc_timer.sv
`timescale 1ns/10ps
module wutc_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control side
  wutc_timer_if.timer tif
);
  logic [15:0] pre_reg; // Prescaler edge count
  logic [15:0] cnt_reg; // Ticks left before expiry
  logic to_reg; // Timeout pulse
  logic [15:0] mask; // Divide mask from code
  logic tick; // Prescaled tick
  logic expire; // Counter at zero on a tick

  // Divide table: mask+1 is the division factor
  always_comb
  begin
    unique case (tif.div_code)
      3'h0: mask = 16'h0000;
      3'h1: mask = 16'h0003;
      3'h2: mask = 16'h0007;
      3'h3: mask = 16'h000F;
      3'h4: mask = 16'h007F;
      3'h5: mask = 16'h03FF;
      3'h6: mask = 16'h1FFF;
      3'h7: mask = 16'hFFFF;
    endcase
  end

  assign tick = tif.src_edge & ((pre_reg & mask) == mask);
  assign expire = tick & (cnt_reg == 16'h0000);
  assign tif.timeout = to_reg;

  // Prescaler and reload counter
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      to_reg <= 1'b0;
    end
    else
    begin
      to_reg <= expire & ~tif.load;
      if (tif.load)
      begin
        // Fresh reload restarts the whole period
        pre_reg <= 16'h0000;
        cnt_reg <= tif.reload;
      end
      else
      begin
        if (tif.src_edge)
          pre_reg <= pre_reg + 16'h0001;
        if (expire)
          cnt_reg <= tif.reload;
        else if (tick)
          cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
endmodule : wutc_timer

// >>> verilog/wutc_top.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
// Overview of operation
// - Prescaler codes 0-7 divide by 1..65536
// - Prescaler staged until sleep config written
// - Decode sleep codes 1, 4, 5, 11
// - Timeout wakes only when wake enabled
// - Reload high byte staged until low write
// - Low byte write applies full 16-bit reload
// - Calibration enable bit starts RC calibration
// - Flag reset write clears both sticky flags
// - Calibration done after about 1 ms
// - Crystal settled bit shown in status
// - Cold start flag at status bit 2
// - Timeout flag at status bit 1
module wutc_top
  import wutc_pkg::*;
#(
  parameter int CALIB_CYCLES_P = wutc_pkg::CALIB_CYCLES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // AXI4-Lite write address
  input wire logic [wutc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [wutc_pkg::DATA_W-1:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [wutc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [wutc_pkg::DATA_W-1:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Slow oscillators, asynchronous
  input wire logic SLOW_CRYSTAL_SOURCE_I,
  input wire logic SLOW_RC_SOURCE_I,
  input wire logic SLOW_CRYSTAL_SETTLED_I,
  // Sleep and wake controls
  output logic SLEEP_RAM_RETAINED_O,
  output logic SLEEP_CRYSTAL_ON_O,
  output logic SLEEP_RC_ON_O,
  output logic WAKE_REQ_O,
  output logic SLOW_RC_CALIB_ENABLE_O
);
  import wutc_pkg::*;

  // Width of the calibration counter
  localparam int CAL_W = $clog2(CALIB_CYCLES_P + 1);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CALIB_CYCLES_P - 1);

  // Write channel state
  logic aw_full_reg; // Write address held
  logic [ADDR_W-1:0] aw_addr_reg; // Held write address
  logic w_full_reg; // Write data held
  logic [DATA_W-1:0] w_data_reg; // Held write data
  logic w_strb0_reg; // Low lane strobe
  logic awready_reg; // Address slot free
  logic wready_reg; // Data slot free
  logic bvalid_reg; // Response pending
  logic [1:0] bresp_reg; // Response code
  // Read channel state
  logic arready_reg; // Read slot free
  logic rvalid_reg; // Read data pending
  logic [DATA_W-1:0] rdata_reg; // Read data
  logic [1:0] rresp_reg; // Read response code

  // Software registers
  logic [2:0] prescale_stage_reg; // Staged prescaler code
  logic [2:0] prescale_reg; // Applied prescaler code
  logic [3:0] sleep_mode_reg; // Sleep mode code
  logic wake_en_reg; // Wake on timeout
  logic [7:0] reload_stage_reg; // Staged high byte
  logic [15:0] reload_reg; // Applied reload value
  logic load_reg; // Reload apply pulse
  logic calib_en_reg; // RC calibration enable
  // Hardware state
  logic [CAL_W-1:0] cal_cnt_reg; // Calibration elapsed cycles
  logic cal_done_reg; // Calibration finished
  logic por_seen_reg; // Cleared only by reset
  logic cold_flag_reg; // Sticky cold start flag
  logic to_flag_reg; // Sticky timeout flag
  logic src_prev_reg; // Last selected source level
  logic edge_reg; // Selected source rising edge
  // Output flops
  logic ram_ret_reg; // RAM retained in sleep
  logic xtal_on_reg; // Crystal kept running
  logic rc_on_reg; // RC kept running
  logic wake_reg; // Wake request pulse

  // Synchronised pins
  logic [2:0] pins_sync; // Settled, RC, crystal
  logic xtal_src; // Crystal level
  logic rc_src; // RC level
  logic xtal_ok; // Crystal settled

  // Handshake and decode wires
  logic aw_take; // Address accepted
  logic w_take; // Data accepted
  logic wr_go; // Write performed now
  logic b_done; // Response taken
  logic aw_full_next; // Next address held
  logic w_full_next; // Next data held
  logic bvalid_next; // Next response pending
  logic ar_take; // Read accepted
  logic rvalid_next; // Next read pending
  logic [9:0] wr_idx; // Write word index
  logic [9:0] rd_idx; // Read word index
  logic wr_hit; // Write to mapped word
  logic rd_hit; // Read from mapped word
  logic wr_en; // Write with low lane
  logic wr_pre; // Prescaler write
  logic wr_sleep; // Sleep config write
  logic wr_rhi; // Reload high write
  logic wr_rlo; // Reload low write
  logic wr_ctl; // Control write
  logic flag_clr; // Flag reset request
  logic [7:0] rd_byte; // Selected read byte
  logic [7:0] status_byte; // Status view
  logic xtal_mode; // Crystal sleep modes
  logic mode_ram; // Sleep retains RAM
  logic mode_rc; // Sleep keeps RC
  logic src_sel; // Selected slow source
  logic [7:0] wbyte; // Low write byte

  // Timer link
  wutc_timer_if tif ();

  // Oscillator pins cross into the bus clock here
  wutc_sync #(
    .W(3)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .d_i({SLOW_CRYSTAL_SETTLED_I, SLOW_RC_SOURCE_I,
          SLOW_CRYSTAL_SOURCE_I}),
    .q_o(pins_sync)
  );

  assign xtal_src = pins_sync[0];
  assign rc_src = pins_sync[1];
  assign xtal_ok = pins_sync[2];

  // Wake-up counter
  wutc_timer u_timer (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .tif(tif)
  );

  assign tif.load = load_reg;
  assign tif.reload = reload_reg;
  assign tif.div_code = prescale_reg;
  assign tif.src_edge = edge_reg;

  // Write handshakes: address and data in either order
  assign aw_take = S_AXI_AWVALID_I & awready_reg;
  assign w_take = S_AXI_WVALID_I & wready_reg;
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign b_done = bvalid_reg & S_AXI_BREADY_I;
  assign aw_full_next = aw_take | (aw_full_reg & ~wr_go);
  assign w_full_next = w_take | (w_full_reg & ~wr_go);
  assign bvalid_next = wr_go | (bvalid_reg & ~b_done);
  // Read handshake
  assign ar_take = S_AXI_ARVALID_I & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~S_AXI_RREADY_I);

  // Address decode
  assign wr_idx = aw_addr_reg[ADDR_W-1:2];
  assign rd_idx = S_AXI_ARADDR_I[ADDR_W-1:2];
  assign wr_hit = (wr_idx >= IDX_PRESCALE) & (wr_idx <= IDX_STATUS);
  assign rd_hit = (rd_idx >= IDX_PRESCALE) & (rd_idx <= IDX_STATUS);
  assign wr_en = wr_go & w_strb0_reg;
  assign wbyte = w_data_reg[7:0];
  assign wr_pre = wr_en & (wr_idx == IDX_PRESCALE);
  assign wr_sleep = wr_en & (wr_idx == IDX_SLEEP);
  assign wr_rhi = wr_en & (wr_idx == IDX_RELOAD_HI);
  assign wr_rlo = wr_en & (wr_idx == IDX_RELOAD_LO);
  assign wr_ctl = wr_en & (wr_idx == IDX_CONTROL);
  // Status index has no write strobe at all
  assign flag_clr = wr_ctl & wbyte[POS_FLAG_CLR];

  // Sleep mode decode; reserved codes keep everything off
  assign mode_ram = (sleep_mode_reg == WUTC_SLEEP_RAM_RETAINED) |
                    (sleep_mode_reg == WUTC_SLEEP_RAM_AND_CRYSTAL) |
                    (sleep_mode_reg == WUTC_SLEEP_RAM_AND_RC);
  assign xtal_mode = (sleep_mode_reg == WUTC_SLEEP_CRYSTAL_ON) |
                     (sleep_mode_reg == WUTC_SLEEP_RAM_AND_CRYSTAL);
  assign mode_rc = (sleep_mode_reg == WUTC_SLEEP_RAM_AND_RC);
  // Timer runs from the crystal only in the crystal modes
  assign src_sel = xtal_mode ? xtal_src : rc_src;

  // Status view, reserved bits zero
  assign status_byte = {2'h0, cal_done_reg, xtal_ok, 1'h0,
                        cold_flag_reg, to_flag_reg, 1'h0};

  // Read mux; write-only words read as zero
  always_comb
  begin
    unique case (rd_idx)
      IDX_SLEEP: rd_byte = {1'h0, sleep_mode_reg, 2'h0, wake_en_reg};
      IDX_RELOAD_LO: rd_byte = reload_reg[7:0];
      IDX_CONTROL: rd_byte = {6'h00, calib_en_reg, 1'h0};
      IDX_STATUS: rd_byte = status_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  // AXI write channel
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      bvalid_reg <= bvalid_next;
      // One write at a time: slots reopen after the response
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg <= ~w_full_next & ~bvalid_next;
      if (aw_take)
        aw_addr_reg <= S_AXI_AWADDR_I;
      if (w_take)
      begin
        w_data_reg <= S_AXI_WDATA_I;
        w_strb0_reg <= S_AXI_WSTRB_I[0];
      end
      if (wr_go)
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // AXI read channel, answer one cycle after address
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      arready_reg <= ~rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Timer configuration registers
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      prescale_stage_reg <= RST_PRESCALE;
      prescale_reg <= RST_PRESCALE;
      sleep_mode_reg <= RST_SLEEP_MODE;
      wake_en_reg <= 1'b0;
      reload_stage_reg <= RST_RELOAD_BYTE;
      reload_reg <= RST_RELOAD;
      load_reg <= 1'b0;
      calib_en_reg <= 1'b0;
    end
    else
    begin
      load_reg <= wr_rlo;
      if (wr_pre)
        prescale_stage_reg <= wbyte[2:0];
      if (wr_sleep)
      begin
        // Staged divider goes live with the sleep write
        prescale_reg <= prescale_stage_reg;
        sleep_mode_reg <= wbyte[POS_MODE_LO+3:POS_MODE_LO];
        wake_en_reg <= wbyte[POS_WAKE_EN];
      end
      if (wr_rhi)
        reload_stage_reg <= wbyte;
      if (wr_rlo)
        reload_reg <= {reload_stage_reg, wbyte};
      if (wr_ctl)
        calib_en_reg <= wbyte[POS_CAL_EN];
    end
  end

  // RC calibration timer; disabling aborts and clears done
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      cal_cnt_reg <= '0;
      cal_done_reg <= 1'b0;
    end
    else if (!calib_en_reg)
    begin
      cal_cnt_reg <= '0;
      cal_done_reg <= 1'b0;
    end
    else if (cal_cnt_reg == CAL_LAST)
      cal_done_reg <= 1'b1;
    else
      cal_cnt_reg <= cal_cnt_reg + 1'b1;
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      por_seen_reg <= 1'b0;
      cold_flag_reg <= 1'b0;
      to_flag_reg <= 1'b0;
    end
    else
    begin
      por_seen_reg <= 1'b1;
      // First cycle after reset marks the cold start
      cold_flag_reg <= ~por_seen_reg |
                       (cold_flag_reg & ~flag_clr);
      to_flag_reg <= tif.timeout |
                     (to_flag_reg & ~flag_clr);
    end
  end

  // Source edge detect and output flops
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      src_prev_reg <= 1'b0;
      edge_reg <= 1'b0;
      ram_ret_reg <= 1'b0;
      xtal_on_reg <= 1'b0;
      rc_on_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      src_prev_reg <= src_sel;
      edge_reg <= src_sel & ~src_prev_reg;
      ram_ret_reg <= mode_ram;
      xtal_on_reg <= xtal_mode;
      rc_on_reg <= mode_rc;
      wake_reg <= tif.timeout & wake_en_reg;
    end
  end

  // Port drive
  assign S_AXI_AWREADY_O = awready_reg;
  assign S_AXI_WREADY_O = wready_reg;
  assign S_AXI_BRESP_O = bresp_reg;
  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_ARREADY_O = arready_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign SLEEP_RAM_RETAINED_O = ram_ret_reg;
  assign SLEEP_CRYSTAL_ON_O = xtal_on_reg;
  assign SLEEP_RC_ON_O = rc_on_reg;
  assign WAKE_REQ_O = wake_reg;
  assign SLOW_RC_CALIB_ENABLE_O = calib_en_reg;
endmodule : wutc_top
